// ==== shared/uti_pkg.sv ====
// Constants shared by the USB and timer interrupt controller files
//
// Summary of operation
// - Control bit 0 is the global enable
// - Control bit 1 enables the USB source
// - Control bit 3 enables the timer source
// - Control bit 4 is the USB request flag
// - Control bit 6 is the timer request flag
// - Control bits 2, 5, 7 read zero
// - Acknowledge clears the global enable
// - Stack full withholds every acknowledge
// - Acknowledge pushes only the program counter
// - Four USB events set the USB flag
// - USB acknowledge calls 04H, clears flag, enable
// - FIFO access sets endpoint bit; firmware clears
// - Suspend sets USB control bit 0, requests
// - Resume sets USB control bit 3, requests
// - Bus reset sets its flag; firmware clears
// - Timer acknowledge calls 0CH, clears flag, enable
// - Interrupt return sets enable; plain return keeps
// - Nesting only once software re-enables
// - Requests are taken on second-phase pulse
// - USB outranks timer when both pending
// - Flags stay until acknowledged or cleared
// - Both sources can wake power-down
// - Flag set before power-down gives no wake
package uti_pkg;

  // ==========================================================
  // Register indices and byte addresses (index times four)
  localparam logic [7:0] IRQ_CTRL_IDX = 8'h0B;
  localparam logic [7:0] USB_CTRL_IDX = 8'h1A;
  localparam logic [7:0] USB_FIFO_IDX = 8'h1B;
  localparam logic [7:0] CORE_STAT_IDX = 8'h20;
  localparam logic [7:0] IRQ_CTRL_ADDR = 8'(IRQ_CTRL_IDX << 2);
  localparam logic [7:0] USB_CTRL_ADDR = 8'(USB_CTRL_IDX << 2);
  localparam logic [7:0] USB_FIFO_ADDR = 8'(USB_FIFO_IDX << 2);
  localparam logic [7:0] CORE_STAT_ADDR = 8'(CORE_STAT_IDX << 2);

  // ==========================================================
  // Interrupt control register fields
  localparam int unsigned GIE_BIT = 0;
  localparam int unsigned USB_EN_BIT = 1;
  localparam int unsigned TMR_EN_BIT = 3;
  localparam int unsigned USB_FLAG_BIT = 4;
  localparam int unsigned TMR_FLAG_BIT = 6;
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;

  // ==========================================================
  // USB control and FIFO access register fields
  localparam int unsigned SUSPEND_BIT = 0;
  localparam int unsigned BUS_RESET_BIT = 2;
  localparam int unsigned RESUME_BIT = 3;
  localparam int unsigned NUM_EP = 3;
  localparam logic [7:0] USB_CTRL_RESET = 8'h00;
  localparam logic [7:0] USB_FIFO_RESET = 8'h00;

  // ==========================================================
  // Core status register fields (read only)
  localparam int unsigned STAT_STACK_FULL_BIT = 0;
  localparam int unsigned STAT_POWER_DOWN_BIT = 1;
  localparam int unsigned STAT_WAKE_BIT = 2;
  localparam int unsigned STAT_IN_SERVICE_BIT = 3;

  // ==========================================================
  // Vector addresses
  localparam logic [11:0] VEC_USB = 12'h004;
  localparam logic [11:0] VEC_TMR = 12'h00C;
  localparam logic [11:0] VEC_RESET = 12'h000;

endpackage

// ==== hdl/uti_usb_events.sv ====
// USB event flags: endpoint FIFO access bits and bus state bits
module uti_usb_events (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] fifo_access_pulse,
  input wire logic suspend_pulse,
  input wire logic resume_pulse,
  input wire logic bus_reset_pulse,
  input wire logic fifo_wr,
  input wire logic ctrl_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] usb_fifo_access_q,
  output logic [7:0] usb_control_q,
  output logic usb_event
);

  // ==========================================================
  // Endpoint access bits; a fresh access beats a firmware clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_fifo_access_q <= uti_pkg::USB_FIFO_RESET;
    end else begin
      // Bits above the last endpoint stay zero; the loop only indexes real endpoints
      usb_fifo_access_q <= 8'h00;
      for (int i = 0; i < uti_pkg::NUM_EP; i++) begin
        usb_fifo_access_q[i] <= fifo_access_pulse[i] |
                                (fifo_wr ? wdata[i] : usb_fifo_access_q[i]);
      end
    end
  end

  // ==========================================================
  // Suspend, resume and bus reset bits, same set-wins policy
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_control_q <= uti_pkg::USB_CTRL_RESET;
    end else begin
      usb_control_q <= 8'h00;
      usb_control_q[uti_pkg::SUSPEND_BIT] <= suspend_pulse |
        (ctrl_wr ? wdata[uti_pkg::SUSPEND_BIT] : usb_control_q[uti_pkg::SUSPEND_BIT]);
      usb_control_q[uti_pkg::RESUME_BIT] <= resume_pulse |
        (ctrl_wr ? wdata[uti_pkg::RESUME_BIT] : usb_control_q[uti_pkg::RESUME_BIT]);
      usb_control_q[uti_pkg::BUS_RESET_BIT] <= bus_reset_pulse |
        (ctrl_wr ? wdata[uti_pkg::BUS_RESET_BIT] : usb_control_q[uti_pkg::BUS_RESET_BIT]);
    end
  end

  // Any of the four events raises the USB request
  assign usb_event = (|fifo_access_pulse) | suspend_pulse | resume_pulse | bus_reset_pulse;

endmodule

// ==== hdl/uti_wake.sv ====
// Power-down wake request from newly pending interrupt flags
module uti_wake (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic power_down,
  input wire logic usb_flag,
  input wire logic tmr_flag,
  output logic wake_req_q
);

  logic pd_q;
  logic usb_mask_q;
  logic tmr_mask_q;
  logic entry;

  assign entry = power_down & ~pd_q;

  // ==========================================================
  // Remember power-down state to find the entry cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= power_down;
    end
  end

  // Flags already set on entry lose their wake ability
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_mask_q <= 1'b0;
      tmr_mask_q <= 1'b0;
    end else if (entry) begin
      usb_mask_q <= usb_flag;
      tmr_mask_q <= tmr_flag;
    end else if (!power_down) begin
      usb_mask_q <= 1'b0;
      tmr_mask_q <= 1'b0;
    end
  end

  // Wake ignores enables: the core decides between vector and next instruction
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= power_down & ~entry &
                    ((usb_flag & ~usb_mask_q) | (tmr_flag & ~tmr_mask_q));
    end
  end

endmodule

// ==== hdl/uti_ctrl.sv ====
// Two-source interrupt controller with APB register access
//
// Implementation choice: the APB slave port.
module uti_ctrl (
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core program sequencer
  input wire logic second_phase_pulse,
  input wire logic stack_full,
  input wire logic return_from_irq_instr,
  input wire logic plain_return_instr,
  input wire logic power_down,
  output logic vector_req,
  output logic [11:0] vector_addr,
  output logic push_pc,
  output logic wake_req,
  // Event sources
  input wire logic [2:0] fifo_access_pulse,
  input wire logic suspend_pulse,
  input wire logic resume_pulse,
  input wire logic bus_reset_pulse,
  input wire logic timer_overflow_pulse
);

  // ==========================================================
  // Declarations
  logic gie_q;
  logic usb_en_q;
  logic tmr_en_q;
  logic usb_flag_q;
  logic tmr_flag_q;
  logic in_service_q;
  logic vector_req_q;
  logic push_pc_q;
  logic [11:0] vector_addr_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux_d;
  logic addr_hit;
  logic setup;
  logic access;
  logic wr_en;
  logic wr_interrupt_enable_and_flags;
  logic wr_usc;
  logic wr_usr;
  logic [7:0] wdata;
  logic [7:0] irq_ctrl_rd;
  logic [7:0] core_stat_rd;
  logic [7:0] usb_fifo_access_q;
  logic [7:0] usb_control_q;
  logic usb_event;
  logic wake_req_q;
  logic usb_pend;
  logic tmr_pend;
  logic take;
  logic ack_usb;
  logic ack_tmr;

  // ==========================================================
  // APB phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign wr_en = access & pwrite;
  assign wdata = pwdata[7:0];
  assign wr_interrupt_enable_and_flags = wr_en & (paddr == uti_pkg::IRQ_CTRL_ADDR);
  assign wr_usc = wr_en & (paddr == uti_pkg::USB_CTRL_ADDR);
  assign wr_usr = wr_en & (paddr == uti_pkg::USB_FIFO_ADDR);

  // Zero wait states: ready rises in the access cycle after each setup
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // Unmapped addresses answer with an error in the same access cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup & ~addr_hit;
    end
  end

  // Read data is captured in setup so it is stable through the access cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux_d;
    end
  end

  // ==========================================================
  // Read views; unused control bits are never stored, so read zero
  always_comb begin
    irq_ctrl_rd = 8'h00;
    irq_ctrl_rd[uti_pkg::GIE_BIT] = gie_q;
    irq_ctrl_rd[uti_pkg::USB_EN_BIT] = usb_en_q;
    irq_ctrl_rd[uti_pkg::TMR_EN_BIT] = tmr_en_q;
    irq_ctrl_rd[uti_pkg::USB_FLAG_BIT] = usb_flag_q;
    irq_ctrl_rd[uti_pkg::TMR_FLAG_BIT] = tmr_flag_q;
  end

  // Core status shows live inputs and controller state
  always_comb begin
    core_stat_rd = 8'h00;
    core_stat_rd[uti_pkg::STAT_STACK_FULL_BIT] = stack_full;
    core_stat_rd[uti_pkg::STAT_POWER_DOWN_BIT] = power_down;
    core_stat_rd[uti_pkg::STAT_WAKE_BIT] = wake_req_q;
    core_stat_rd[uti_pkg::STAT_IN_SERVICE_BIT] = in_service_q;
  end

  // Address decode and read multiplexer
  always_comb begin
    rd_mux_d = 32'h00000000;
    addr_hit = 1'b1;
    unique case (paddr)
      uti_pkg::IRQ_CTRL_ADDR: begin
        rd_mux_d[7:0] = irq_ctrl_rd;
      end
      uti_pkg::USB_CTRL_ADDR: begin
        rd_mux_d[7:0] = usb_control_q;
      end
      uti_pkg::USB_FIFO_ADDR: begin
        rd_mux_d[7:0] = usb_fifo_access_q;
      end
      uti_pkg::CORE_STAT_ADDR: begin
        rd_mux_d[7:0] = core_stat_rd;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // USB event flags and power-down wake
  uti_usb_events u_usb_events (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .fifo_access_pulse(fifo_access_pulse),
    .suspend_pulse(suspend_pulse),
    .resume_pulse(resume_pulse),
    .bus_reset_pulse(bus_reset_pulse),
    .fifo_wr(wr_usr),
    .ctrl_wr(wr_usc),
    .wdata(wdata),
    .usb_fifo_access_q(usb_fifo_access_q),
    .usb_control_q(usb_control_q),
    .usb_event(usb_event)
  );

  uti_wake u_wake (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .power_down(power_down),
    .usb_flag(usb_flag_q),
    .tmr_flag(tmr_flag_q),
    .wake_req_q(wake_req_q)
  );

  // ==========================================================
  // Acknowledge decision, only on the second-phase pulse
  assign usb_pend = usb_flag_q & usb_en_q;
  assign tmr_pend = tmr_flag_q & tmr_en_q;
  // Registered flags only: an event in the pulse cycle waits for the next pulse
  assign take = second_phase_pulse & gie_q & ~stack_full & (usb_pend | tmr_pend);
  assign ack_usb = take & usb_pend;
  assign ack_tmr = take & ~usb_pend & tmr_pend;

  // Global enable: acknowledge clears, interrupt return sets, else software
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gie_q <= uti_pkg::IRQ_CTRL_RESET[uti_pkg::GIE_BIT];
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (return_from_irq_instr) begin
      gie_q <= 1'b1;
    end else if (wr_interrupt_enable_and_flags) begin
      gie_q <= wdata[uti_pkg::GIE_BIT];
    end
  end

  // Source enables are software only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_en_q <= uti_pkg::IRQ_CTRL_RESET[uti_pkg::USB_EN_BIT];
      tmr_en_q <= uti_pkg::IRQ_CTRL_RESET[uti_pkg::TMR_EN_BIT];
    end else if (wr_interrupt_enable_and_flags) begin
      usb_en_q <= wdata[uti_pkg::USB_EN_BIT];
      tmr_en_q <= wdata[uti_pkg::TMR_EN_BIT];
    end
  end

  // Request flags: a new event beats both the acknowledge clear and a write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_flag_q <= uti_pkg::IRQ_CTRL_RESET[uti_pkg::USB_FLAG_BIT];
      tmr_flag_q <= uti_pkg::IRQ_CTRL_RESET[uti_pkg::TMR_FLAG_BIT];
    end else begin
      usb_flag_q <= usb_event | (~ack_usb &
        (wr_interrupt_enable_and_flags ? wdata[uti_pkg::USB_FLAG_BIT] : usb_flag_q));
      tmr_flag_q <= timer_overflow_pulse | (~ack_tmr &
        (wr_interrupt_enable_and_flags ? wdata[uti_pkg::TMR_FLAG_BIT] : tmr_flag_q));
    end
  end

  // ==========================================================
  // Vector request towards the sequencer; only the PC is pushed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_req_q <= 1'b0;
      push_pc_q <= 1'b0;
    end else begin
      vector_req_q <= take;
      push_pc_q <= take;
    end
  end

  // Address holds after the request so the sequencer may sample it late
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_addr_q <= uti_pkg::VEC_RESET;
    end else if (ack_usb) begin
      vector_addr_q <= uti_pkg::VEC_USB;
    end else if (ack_tmr) begin
      vector_addr_q <= uti_pkg::VEC_TMR;
    end
  end

  // In-service marker: set on acknowledge, ended by either return
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_service_q <= 1'b0;
    end else if (take) begin
      in_service_q <= 1'b1;
    end else if (return_from_irq_instr | plain_return_instr) begin
      in_service_q <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign vector_req = vector_req_q;
  assign vector_addr = vector_addr_q;
  assign push_pc = push_pc_q;
  assign wake_req = wake_req_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Every vector request leaves the global enable off
  gie_after_ack_a: assert property (
    vector_req_q |-> !gie_q)
    else $error("global enable still set after acknowledge");

  // Nothing is taken while the stack is full
  stack_full_hold_a: assert property (
    (second_phase_pulse && stack_full) |=> !vector_req_q)
    else $error("acknowledge taken with stack full");

  // Requests appear only one cycle after a second-phase pulse
  pulse_timing_a: assert property (
    vector_req_q |-> $past(second_phase_pulse))
    else $error("vector request without second-phase pulse");

  // Enabled pending USB request with enable and room is taken to its vector
  usb_vector_a: assert property (
    (second_phase_pulse && gie_q && !stack_full && usb_flag_q && usb_en_q)
    |=> vector_req_q && vector_addr_q == uti_pkg::VEC_USB)
    else $error("USB request not vectored to its address");

  // Timer alone goes to its own vector and its flag drops
  timer_vector_a: assert property (
    (second_phase_pulse && gie_q && !stack_full && tmr_flag_q && tmr_en_q
     && !(usb_flag_q && usb_en_q) && !timer_overflow_pulse)
    |=> vector_req_q && vector_addr_q == uti_pkg::VEC_TMR && !tmr_flag_q)
    else $error("timer request not vectored or flag kept");

  // Both pending: USB first, timer flag stays for later
  priority_order_a: assert property (
    (take && usb_pend && tmr_pend && !wr_interrupt_enable_and_flags)
    |=> vector_addr_q == uti_pkg::VEC_USB && tmr_flag_q)
    else $error("timer served ahead of USB");

  // Interrupt return re-enables
  return_from_irq_instr_enable_a: assert property (
    (return_from_irq_instr && !take) |=> gie_q)
    else $error("interrupt return did not set global enable");

  // Plain return leaves the enable alone
  ret_keep_a: assert property (
    (plain_return_instr && !return_from_irq_instr && !wr_interrupt_enable_and_flags && !take)
    |=> gie_q == $past(gie_q))
    else $error("plain return changed global enable");

  // USB flag persists without acknowledge or software write
  flag_persist_a: assert property (
    (usb_flag_q && !ack_usb && !wr_interrupt_enable_and_flags) |=> usb_flag_q)
    else $error("USB flag dropped on its own");

  // Each USB event source raises its flag on the next edge
  event_sets_a: assert property (
    usb_event |=> usb_flag_q)
    else $error("USB event did not set the flag");

  // Timer overflow sets its flag
  timer_sets_a: assert property (
    timer_overflow_pulse |=> tmr_flag_q)
    else $error("timer overflow did not set the flag");

  // Control register reads never show unused bits
  reserved_zero_a: assert property (
    (setup && !pwrite && paddr == uti_pkg::IRQ_CTRL_ADDR)
    |=> prdata_q[2] == 1'b0 && prdata_q[5] == 1'b0 && prdata_q[7] == 1'b0)
    else $error("reserved control bits read non-zero");

  // Software re-enable inside a routine allows a nested acknowledge
  nest_allow_a: assert property (
    (wr_interrupt_enable_and_flags && wdata[uti_pkg::GIE_BIT] && !take && !return_from_irq_instr)
    |=> gie_q)
    else $error("software could not re-enable for nesting");

endmodule

// ==== tb/uti_core_model.sv ====
// Core sequencer stand-in: phase pulses, call stack depth and return instructions
module uti_core_model #(
  parameter int PHASE_LEN = 4,
  parameter int STACK_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic push_pc,
  input wire logic call_req,
  input wire logic return_from_irq_instr_req,
  input wire logic ret_req,
  input wire logic slow,
  output logic second_phase_pulse,
  output logic stack_full,
  output logic return_from_irq_instr,
  output logic plain_return_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase_q;
  logic [3:0] depth_q;
  logic push;
  logic pop;
  // ==========================================================
  // Instruction phases; slow mode doubles the cycle length
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 4'h0;
      second_phase_pulse <= 1'b0;
    end else begin
      phase_q <= (phase_q >= 4'(slow ? 2 * PHASE_LEN - 1 : PHASE_LEN - 1)) ? 4'h0 : phase_q + 4'h1;
      second_phase_pulse <= (phase_q == 4'h1);
    end
  end
  // ==========================================================
  // Stack depth: acknowledges push only the return address, returns pop
  assign push = push_pc || call_req;
  assign pop = return_from_irq_instr_req || ret_req;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      depth_q <= 4'h0;
    end else if (push && !pop && depth_q < 4'(STACK_DEPTH)) begin
      depth_q <= depth_q + 4'h1;
    end else if (pop && !push && depth_q != 4'h0) begin
      depth_q <= depth_q - 4'h1;
    end
  end
  // Full flag only drops once a return has popped an entry
  assign stack_full = (depth_q == 4'(STACK_DEPTH));
  // ==========================================================
  // Return instructions as one-cycle pulses
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      return_from_irq_instr <= 1'b0;
      plain_return_instr <= 1'b0;
    end else begin
      return_from_irq_instr <= return_from_irq_instr_req;
      plain_return_instr <= ret_req;
    end
  end
endmodule

// ==== tb/uti_ctrl_bench.sv ====
// Self-checking bench for the USB and timer interrupt controller
module uti_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus, responses and bookkeeping
  logic ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, second_phase_pulse, stack_full, return_from_irq_instr;
  logic plain_return_instr, power_down = 1'b0, vector_req, push_pc, wake_req, slow = 1'b0;
  logic [11:0] vector_addr;
  logic [2:0] fifo_access_pulse = 3'h0;
  logic suspend_pulse = 1'b0, resume_pulse = 1'b0, bus_reset_pulse = 1'b0;
  logic timer_overflow_pulse = 1'b0, call_req = 1'b0, return_from_irq_instr_req = 1'b0, ret_req = 1'b0;
  int fail_count = 0, check_count = 0;
  localparam logic [7:0] IRQ = uti_pkg::IRQ_CTRL_ADDR;
  localparam logic [7:0] STAT = uti_pkg::CORE_STAT_ADDR;

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  uti_ctrl DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .second_phase_pulse(second_phase_pulse), .stack_full(stack_full),
    .return_from_irq_instr(return_from_irq_instr), .plain_return_instr(plain_return_instr),
    .power_down(power_down), .vector_req(vector_req), .vector_addr(vector_addr),
    .push_pc(push_pc), .wake_req(wake_req), .fifo_access_pulse(fifo_access_pulse),
    .suspend_pulse(suspend_pulse), .resume_pulse(resume_pulse),
    .bus_reset_pulse(bus_reset_pulse), .timer_overflow_pulse(timer_overflow_pulse));

  uti_core_model core (.ref_clk(ref_clk), .reset_n(reset_n), .push_pc(push_pc),
    .call_req(call_req), .return_from_irq_instr_req(return_from_irq_instr_req), .ret_req(ret_req), .slow(slow),
    .second_phase_pulse(second_phase_pulse), .stack_full(stack_full),
    .return_from_irq_instr(return_from_irq_instr), .plain_return_instr(plain_return_instr));

  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail_count++;
      wrap_up();
    end
  endtask

  // Event sources: 0..2 endpoints, 3 suspend, 4 resume, 5 bus reset, 6 timer
  task automatic evt(input int k);
    @(posedge ref_clk);
    fifo_access_pulse <= (k < 3) ? 3'(1 << k) : 3'h0;
    suspend_pulse <= (k == 3);
    resume_pulse <= (k == 4);
    bus_reset_pulse <= (k == 5);
    timer_overflow_pulse <= (k == 6);
    @(posedge ref_clk);
    fifo_access_pulse <= 3'h0;
    {suspend_pulse, resume_pulse, bus_reset_pulse, timer_overflow_pulse} <= 4'h0;
  endtask

  // Core instruction: 0 call, 1 interrupt return, 2 plain return
  task automatic instr(input int k);
    @(posedge ref_clk);
    call_req <= (k == 0);
    return_from_irq_instr_req <= (k == 1);
    ret_req <= (k == 2);
    @(posedge ref_clk);
    {call_req, return_from_irq_instr_req, ret_req} <= 3'h0;
  endtask

  task automatic expect_vec(input logic [11:0] exp);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (vector_req !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk("vector_req", 32'h1, 32'(vector_req));
    chk("vector_addr", 32'(exp), 32'(vector_addr));
    chk("push_pc", 32'h1, 32'(push_pc));
    if (n == 40) wrap_up();
  endtask

  task automatic expect_none(input int cycles);
    int seen;
    seen = 0;
    repeat (cycles) begin
      @(negedge ref_clk);
      if (vector_req !== 1'b0) seen++;
    end
    chk("quiet vector_req", 32'h0, 32'(seen));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, IRQ, 8'h00);
    chk("irq ctrl reset", 32'h0, rd);
    apb(1'b1, IRQ, 8'hFE);
    apb(1'b0, IRQ, 8'h00);
    chk("irq ctrl bits", 32'h5A, rd);
    apb(1'b1, IRQ, 8'h01);
    apb(1'b0, IRQ, 8'h00);
    chk("global enable", 32'h1, rd);
    apb(1'b1, IRQ, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped error", 32'h1, 32'(err));
  endtask

  task automatic t_usb_sources();
    logic [7:0] a;
    logic [31:0] e;
    for (int k = 0; k < 6; k++) begin
      a = (k < 3) ? uti_pkg::USB_FIFO_ADDR : uti_pkg::USB_CTRL_ADDR;
      e = (k < 3) ? 32'h1 << k : (k == 3) ? 32'h1 << uti_pkg::SUSPEND_BIT :
        (k == 4) ? 32'h1 << uti_pkg::RESUME_BIT : 32'h1 << uti_pkg::BUS_RESET_BIT;
      evt(k);
      repeat (10) @(posedge ref_clk);
      apb(1'b0, IRQ, 8'h00);
      chk("usb flag held", 32'h10, rd);
      apb(1'b0, a, 8'h00);
      chk("usb source bit", e, rd);
      apb(1'b1, a, 8'h00);
      apb(1'b1, IRQ, 8'h00);
    end
  endtask

  task automatic t_usb_ack();
    apb(1'b1, IRQ, 8'h0B);
    evt(0);
    expect_vec(uti_pkg::VEC_USB);
    apb(1'b0, IRQ, 8'h00);
    chk("after usb ack", 32'h0A, rd);
    evt(6);
    expect_none(24);
    apb(1'b0, IRQ, 8'h00);
    chk("timer flag", 32'h4A, rd);
    instr(1);
    expect_vec(uti_pkg::VEC_TMR);
    instr(2);
    expect_none(12);
    apb(1'b0, IRQ, 8'h00);
    chk("plain return", 32'h0A, rd);
    apb(1'b1, uti_pkg::USB_FIFO_ADDR, 8'h00);
  endtask

  task automatic t_priority();
    evt(6);
    evt(3);
    apb(1'b0, IRQ, 8'h00);
    chk("both pending", 32'h5A, rd);
    apb(1'b1, IRQ, 8'h5B);
    expect_vec(uti_pkg::VEC_USB);
    apb(1'b1, IRQ, 8'h4B);
    expect_vec(uti_pkg::VEC_TMR);
    instr(2);
    instr(2);
    apb(1'b1, uti_pkg::USB_CTRL_ADDR, 8'h00);
  endtask

  task automatic t_stack();
    // Long instruction cycles: the held request must still wait for a pulse
    slow <= 1'b1;
    repeat (4) instr(0);
    apb(1'b1, IRQ, 8'h03);
    evt(1);
    expect_none(24);
    apb(1'b0, STAT, 8'h00);
    chk("stack full bit", 32'h1, 32'(rd[uti_pkg::STAT_STACK_FULL_BIT]));
    instr(2);
    expect_vec(uti_pkg::VEC_USB);
    repeat (4) instr(2);
    apb(1'b1, uti_pkg::USB_FIFO_ADDR, 8'h00);
    slow <= 1'b0;
  endtask

  task automatic t_wake();
    apb(1'b1, IRQ, 8'h00);
    evt(6);
    @(posedge ref_clk);
    power_down <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("wake old flag", 32'h0, 32'(wake_req));
    evt(0);
    repeat (4) @(negedge ref_clk);
    chk("wake new flag", 32'h1, 32'(wake_req));
    apb(1'b0, STAT, 8'h00);
    chk("wake status", 32'h1, 32'(rd[uti_pkg::STAT_WAKE_BIT]));
    @(posedge ref_clk);
    power_down <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("wake dropped", 32'h0, 32'(wake_req));
  endtask

  // ==========================================================
  // Main sequence and run limit
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_usb_sources();
    t_usb_ack();
    t_priority();
    t_stack();
    t_wake();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
endmodule
